// ### bench/cfc_host.sv
// Host model, master of the register port.
// Shares mclk with the register bank.
module cfc_host (
	input wire mclk,
	input wire [7:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	task wr(input [7:0] a, d);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge mclk);
		{reg_wdata, reg_wr} <= {~d, 1'b0};
		#1;
	endtask
	task rd(input [7:0] a, output [7:0] q);
		@(posedge mclk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
endmodule

// ### bench/cfc_mon_monitor.sv
// Port checker for the control seven register bank.
// Bound onto cfc_regbank; OVP timeout of 5 cycles assumed.
module cfc_mon (
	input wire mclk,
	input wire rst_b,
	input wire reg_wr,
	input wire reg_rd,
	input wire reg_reset_req,
	input wire watchdog_expire,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire battery_overvoltage,
	input wire usb_data_line_detection_done,
	input wire [1:0] charge_current_monitor_select,
	input wire [1:0] charge_voltage_trim,
	input wire [1:0] input_voltage_regulation_offset,
	input wire direct_charge_enable_pin,
	input wire stat_led_oe_b,
	input wire safety_timer_restart
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wire [1:0] tr = charge_voltage_trim, of = input_voltage_regulation_offset;
	wire dc = direct_charge_enable_pin, bo = battery_overvoltage;
	wire ww = reg_wr && reg_addr == 8'h0f && !reg_reset_req && !watchdog_expire;
	property p_tr; ww |=> tr == $past(reg_wdata[7:6]); endproperty
	a_tr: assert property (p_tr) else $error("trim");
	property p_dc; ww && !bo |=> dc == $past(reg_wdata[4]); endproperty
	a_dc: assert property (p_dc) else $error("pin");
	property p_of; ww |=> of == $past(reg_wdata[1:0]); endproperty
	a_of: assert property (p_of) else $error("offset");
	property p_rr; reg_reset_req |=> !tr && !dc && !of && safety_timer_restart;
	endproperty
	a_rr: assert property (p_rr) else $error("reset");
	property p_wd; watchdog_expire && !reg_reset_req |=> !tr && !dc
		&& of == $past(of); endproperty
	a_wd: assert property (p_wd) else $error("watchdog");
	property p_ld; charge_current_monitor_select != 2'h1
		&& $past(charge_current_monitor_select) != 2'h1 |-> stat_led_oe_b;
	endproperty
	a_ld: assert property (p_ld) else $error("led");
	property p_ov; (bo && !reg_wr) [*8] |-> !dc; endproperty
	a_ov: assert property (p_ov) else $error("timeout");
	property p_dt; usb_data_line_detection_done ##2 reg_rd
		&& reg_addr == 8'h0e |=> reg_rdata[7]; endproperty
	a_dt: assert property (p_dt) else $error("flag");
	c_wr: cover property (ww);
	c_ov: cover property (bo [*8]);
	c_rr: cover property (reg_reset_req ##1 safety_timer_restart);
endmodule
bind cfc_regbank cfc_mon mon_u (.*);

// ### bench/cfc_regbank_tb.sv
// Bench for the control seven register bank.
// Host model drives the register port.
module cfc_regbank_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_b = 0, battery_overvoltage = 0;
	logic [1:0] charge_current_monitor_select = 2'h0;
	logic [4:0] ev = 5'h00;
	logic [7:0] r = 8'h14, q;
	wire reg_wr, reg_rd, direct_charge_enable_pin, stat_led_out, stat_led_oe_b;
	wire safety_timer_restart, reg_reset_req, watchdog_expire, source_plug_in;
	wire force_source_redetect, usb_data_line_detection_done;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [1:0] charge_voltage_trim, input_voltage_regulation_offset;
	wire [4:0] fl = {charge_voltage_trim, direct_charge_enable_pin,
		input_voltage_regulation_offset};
	int n_errors = 0, tests_run = 0, n, m;
	assign {reg_reset_req, watchdog_expire, source_plug_in,
		force_source_redetect, usb_data_line_detection_done} = ev;
	always #5 mclk = ~mclk;
	cfc_host hst_u (.*);
	cfc_regbank #(.LED_SEC_CYC(8), .OVP_TMO_CYC(5)) dut_u (.*);
	function automatic [7:0] lf(input [7:0] v);
		lf = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic [7:0] lows(input int k);
		lows = (k == 0) ? 8'h00 : 8'h80 >> k;
	endfunction
	task ck(input string s, input [7:0] e, g);
		tests_run++;
		if (g !== e) n_errors++;
		if (g !== e) $display("wrong value %s exp %h got %h", s, e, g);
	endtask
	task ev1(input [4:0] v);
		@(posedge mclk) ev <= v;
		@(posedge mclk) ev <= 5'h00;
	endtask
	task rdc(input [7:0] a, e);
		hst_u.rd(a, q);
		ck("rdata", e, q);
	endtask
	task conclude;
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1;
		rdc(8'h0f, 8'h00);
		for (m = 0; m < 8; m++) begin
			hst_u.wr(8'h0f, r);
			ck("fields", {r[7:6], r[4], r[1:0]}, fl);
			rdc(8'h0f, r);
			r = lf(r);
		end
		@(posedge mclk) charge_current_monitor_select <= 2'h1;
		for (m = 0; m < 4; m++) begin
			hst_u.wr(8'h0f, {m[1:0], 2'h0});
			repeat (3) @(posedge mclk);
			n = 0;
			repeat (64) @(posedge mclk) n += !stat_led_oe_b;
			ck("led", lows(m), n[7:0]);
			ck("led out", 8'h00, stat_led_out);
		end
		@(posedge mclk) charge_current_monitor_select <= 2'h2;
		hst_u.wr(8'h0f, 8'h10);
		for (m = 0; m < 8; m++) @(posedge mclk) battery_overvoltage <= m != 3;
		#1 ck("pin", 8'h01, direct_charge_enable_pin);
		repeat (10) @(posedge mclk);
		#1 ck("pin", 8'h00, direct_charge_enable_pin);
		@(posedge mclk) battery_overvoltage <= 0;
		hst_u.wr(8'h0f, 8'hff);
		ev1(5'h08);
		rdc(8'h0f, 8'h03);
		ev1(5'h10);
		rdc(8'h0f, 8'h00);
		ev1(5'h04);
		rdc(8'h0e, 8'h00);
		ev1(5'h01);
		rdc(8'h0e, 8'h80);
		hst_u.wr(8'h0e, 8'h00);
		rdc(8'h0e, 8'h80);
		ev1(5'h02);
		rdc(8'h0e, 8'h00);
		rdc(8'h30, 8'h00);
		conclude;
	end
endmodule

// ### rtl/cfc_regbank.v
// Register bank holding the charger flag and control seven registers.
// Assumes a synchronous register port driven by the I2C slave logic.
// Assumes event inputs are one-cycle pulses in the mclk domain.
`include "cfc_regs.vh"
module cfc_regbank #(
	parameter [31:0] LED_SEC_CYC = `CFC_CLK_HZ,
	parameter [31:0] OVP_TMO_CYC = (`CFC_CLK_HZ / 1000) * `CFC_OVP_TMO_MS
) (
	input wire mclk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire reg_reset_req,
	input wire watchdog_expire,
	input wire source_plug_in,
	input wire force_source_redetect,
	input wire usb_data_line_detection_done,
	input wire battery_overvoltage,
	input wire [1:0] charge_current_monitor_select,
	output reg direct_charge_enable_pin,
	output reg stat_led_out,
	output reg stat_led_oe_b,
	output reg [1:0] charge_voltage_trim,
	output reg [1:0] input_voltage_regulation_offset,
	output reg safety_timer_restart
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;
	localparam [31:0] PERIOD1 = (`CFC_LED_ON_S + `CFC_LED_OFF1_S) * 4;
	localparam [31:0] PERIOD3 = (`CFC_LED_ON_S + `CFC_LED_OFF3_S) * 4;
	localparam [7:0] CTRL_RST = `CFC_CTRL7_RST;

	reg [2:0] det_state_r;
	reg [7:0] ctrl_r;
	reg [7:0] ctrl_nxt;
	reg [31:0] ovp_cnt_r;
	reg [31:0] sec_cnt_r;
	reg [31:0] quarter_r;
	reg [1:0] led_mode;
	reg led_drive_low;
	wire ovp_expired;
	wire ctrl_wr;
	wire det_start;

	function addr_hit;
		input [7:0] a;
		input [7:0] b;
		begin
			addr_hit = (a == b);
		end
	endfunction

	// Blink pattern: high while the LED pin is pulled low
	function led_low;
		input [1:0] mode;
		input [31:0] q;
		begin
			case (mode)
				2'h1: led_low = 1'b1;
				2'h2: led_low = ((q % PERIOD1) < `CFC_LED_ON_S * 4);
				2'h3: led_low = (q < `CFC_LED_ON_S * 4);
				default: led_low = 1'b0;
			endcase
		end
	endfunction

	// Read mux; flag register shows only the done bit
	function [7:0] read_word;
		input [7:0] a;
		input done;
		input [7:0] ctrl;
		begin
			if (addr_hit(a, `CFC_ADDR_FLAGS)) begin
				read_word = {done, 7'h00};
			end else if (addr_hit(a, `CFC_ADDR_CTRL7)) begin
				read_word = ctrl;
			end else begin
				read_word = 8'h00;
			end
		end
	endfunction

	assign det_start = source_plug_in || force_source_redetect;

	// Detection state: done flag visible only in ST_DONE
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			det_state_r <= ST_IDLE;
		end else begin
			case (det_state_r)
				ST_IDLE: begin
					if (det_start) begin
						det_state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (usb_data_line_detection_done) begin
						det_state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (det_start) begin
						det_state_r <= ST_RUN;
					end
				end
				default: begin
					det_state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Overvoltage duration counter, only while direct charge enabled
	assign ovp_expired = (ovp_cnt_r >= OVP_TMO_CYC - 32'h0000_0001);
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ovp_cnt_r <= 32'h0000_0000;
		end else if (!battery_overvoltage || !ctrl_r[`CFC_DIRECT_CHARGE_ENABLE_PIN_BIT]) begin
			ovp_cnt_r <= 32'h0000_0000;
		end else if (!ovp_expired) begin
			ovp_cnt_r <= ovp_cnt_r + 32'h0000_0001;
		end
	end

	// Control register update; flag register has no write path
	assign ctrl_wr = reg_wr && addr_hit(reg_addr, `CFC_ADDR_CTRL7);
	always @* begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = reg_wdata;
		end
		if (battery_overvoltage && ovp_expired) begin
			ctrl_nxt[`CFC_DIRECT_CHARGE_ENABLE_PIN_BIT] = 1'b0;
		end
		if (reg_reset_req) begin
			ctrl_nxt = `CFC_CTRL7_RST;
		end else if (watchdog_expire) begin
			ctrl_nxt[7:2] = CTRL_RST[7:2];
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `CFC_CTRL7_RST;
			safety_timer_restart <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			safety_timer_restart <= reg_reset_req;
		end
	end

	// Field outputs
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			direct_charge_enable_pin <= 1'b0;
			charge_voltage_trim <= `CFC_TRIM_NONE;
			input_voltage_regulation_offset <= 2'h0;
		end else begin
			direct_charge_enable_pin <= ctrl_nxt[`CFC_DIRECT_CHARGE_ENABLE_PIN_BIT];
			charge_voltage_trim <= ctrl_nxt[`CFC_TRIM_HI:`CFC_TRIM_LO];
			input_voltage_regulation_offset <=
				ctrl_nxt[`CFC_OFS_HI:`CFC_OFS_LO];
		end
	end

	// Quarter-second ticks for blink patterns
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sec_cnt_r <= 32'h0000_0000;
			quarter_r <= 32'h0000_0000;
		end else if (sec_cnt_r >= (LED_SEC_CYC >> 2) - 32'h0000_0001) begin
			sec_cnt_r <= 32'h0000_0000;
			if (quarter_r >= PERIOD3 - 32'h0000_0001) begin
				quarter_r <= 32'h0000_0000;
			end else begin
				quarter_r <= quarter_r + 32'h0000_0001;
			end
		end else begin
			sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
		end
	end

	// LED pattern decode
	always @* begin
		led_mode = ctrl_r[`CFC_LED_HI:`CFC_LED_LO];
		if (charge_current_monitor_select != `CFC_MON_LED) begin
			led_mode = 2'h0;
		end
		led_drive_low = led_low(led_mode, quarter_r);
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stat_led_out <= 1'b0;
			stat_led_oe_b <= 1'b1;
		end else begin
			stat_led_out <= 1'b0;
			stat_led_oe_b <= ~led_drive_low;
		end
	end

	// Read data
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= read_word(reg_addr, det_state_r == ST_DONE, ctrl_r);
		end
	end
endmodule

// ### rtl/cfc_regs.vh
// Constants for the charger flag and control seven register pair.
// Assumes inclusion by the register bank only.
`ifndef CFC_REGS_VH
`define CFC_REGS_VH
`define CFC_ADDR_FLAGS 8'h0e
`define CFC_ADDR_CTRL7 8'h0f
`define CFC_CTRL7_RST 8'h00
`define CFC_TRIM_HI 7
`define CFC_TRIM_LO 6
`define CFC_RSVD_BIT 5
`define CFC_DIRECT_CHARGE_ENABLE_PIN_BIT 4
`define CFC_LED_HI 3
`define CFC_LED_LO 2
`define CFC_OFS_HI 1
`define CFC_OFS_LO 0
`define CFC_DET_BIT 7
`define CFC_MON_LED 2'h1
`define CFC_CLK_HZ 100000000
`define CFC_LED_ON_S 1
`define CFC_LED_OFF1_S 1
`define CFC_LED_OFF3_S 3
`define CFC_OVP_TMO_MS 1
`define CFC_TRIM_NONE 2'h0
`define CFC_TRIM_P8 2'h1
`define CFC_TRIM_M8 2'h2
`define CFC_TRIM_M16 2'h3
`endif
